// ==== design/usr_pkg.sv ====
// Package for the serial channel status reporting block
`default_nettype none
package usr_pkg;
   // Register byte addresses (Avalon word aligned)
   localparam logic [3:0] ADDR_DMA_INT_STATUS = 4'h0;
   localparam logic [3:0] ADDR_STATUS_CHANGE = 4'h4;
   localparam logic [3:0] ADDR_INT_CONTROL = 4'h8;
   localparam int ADDR_W = 4;
   // Field positions of the DMA/interrupt status register
   localparam int DIS_HEAD_BREAK = 15;
   localparam int DIS_RX_EMPTY = 14;
   localparam int DIS_FRAMING = 13;
   localparam int DIS_PARITY = 12;
   localparam int DIS_OVERRUN = 11;
   localparam int DIS_ERR_SUM = 10;
   localparam int DIS_TIMEOUT = 9;
   localparam int DIS_TX_REQ = 8;
   localparam int DIS_RX_REQ = 7;
   localparam int DIS_STAT_SUM = 6;
   localparam int DIS_COUNT_LSB = 0;
   localparam int COUNT_W = 5;
   // Field positions of the status change register
   localparam int SC_OVERRUN = 5;
   localparam int SC_CTS = 4;
   localparam int SC_BRK_PROG = 3;
   localparam int SC_TX_SPACE = 2;
   localparam int SC_TX_ALL = 1;
   localparam int SC_BRK_DET = 0;
   // Status select field width and receive FIFO depth
   localparam int SEL_W = 5;
   localparam int RX_DEPTH = 2;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h02;
   // Reset values
   localparam logic RST_ONE = 1'b1;
   localparam logic RST_ZERO = 1'b0;
   // One receive FIFO entry's per-character status
   typedef struct packed {
      logic brk;
      logic framing;
      logic parity;
      logic overrun;
   } usr_rx_stat_s;
endpackage : usr_pkg
`default_nettype wire

// ==== design/usr_status.sv ====
// Status reporting logic for one serial channel
`default_nettype none
module usr_status (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [usr_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Receiver events (same clock)
   input wire logic rx_push_i,
   input wire usr_pkg::usr_rx_stat_s rx_push_stat_i,
   input wire logic rx_pop_i,
   input wire logic rx_timeout_i,
   input wire logic break_start_i,
   input wire logic break_active_i,
   // Transmitter status (same clock)
   input wire logic tx_space_i,
   input wire logic tx_all_empty_i,
   // Clear-to-send pin (asynchronous)
   input wire logic cts_pin_i,
   // Status outputs
   output logic exception_interrupt_o,
   output logic rx_pop_ok_o
);
   // -----------------------------------------------------------------
   // Receive FIFO status shadow
   // -----------------------------------------------------------------
   usr_pkg::usr_rx_stat_s stat_mem_r [usr_pkg::RX_DEPTH];
   logic rd_ptr_r;
   logic wr_ptr_r;
   logic [usr_pkg::COUNT_W-1:0] count_r;
   logic [usr_pkg::COUNT_W-1:0] count_nxt;
   wire logic do_pop = rx_pop_i && (count_r != '0);
   wire logic do_push = rx_push_i && ((count_r != usr_pkg::COUNT_MAX) || do_pop);
   wire logic lost_char = rx_push_i && !do_push;
   wire usr_pkg::usr_rx_stat_s head_stat = (count_r == '0) ? '0 : stat_mem_r[rd_ptr_r];
   wire logic rx_empty = (count_r == '0);
   assign rx_pop_ok_o = !rx_empty;

   // Occupancy count next value
   always_comb begin
      count_nxt = count_r;
      if (do_push && !do_pop) begin
         count_nxt = count_r + 5'h01;
      end else if (do_pop && !do_push) begin
         count_nxt = count_r - 5'h01;
      end
   end

   // Entry storage and pointers; reading data moves the head on
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            stat_mem_r[wr_ptr_r] <= rx_push_stat_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (do_pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Clear-to-send synchroniser
   // -----------------------------------------------------------------
   logic cts_meta_r;
   logic cts_sync_r;
   logic cts_prev_r;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cts_meta_r <= 1'b0;
         cts_sync_r <= 1'b0;
         cts_prev_r <= 1'b0;
      end else begin
         cts_meta_r <= cts_pin_i;
         cts_sync_r <= cts_meta_r;
         cts_prev_r <= cts_sync_r;
      end
   end
   wire logic cts_change = cts_sync_r ^ cts_prev_r;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire logic sel_dis = (avs_address_i == usr_pkg::ADDR_DMA_INT_STATUS);
   wire logic sel_sc = (avs_address_i == usr_pkg::ADDR_STATUS_CHANGE);
   wire logic sel_ic = (avs_address_i == usr_pkg::ADDR_INT_CONTROL);
   wire logic wr_dis = avs_write_i && sel_dis;
   wire logic wr_sc = avs_write_i && sel_sc;
   wire logic wr_ic = avs_write_i && sel_ic && avs_byteenable_i[0];
   wire logic lane1 = avs_byteenable_i[1];
   wire logic lane0 = avs_byteenable_i[0];
   // Writing 0 clears a sticky bit; writing 1 leaves it
   wire logic clr_err = wr_dis && lane1 && !avs_writedata_i[usr_pkg::DIS_ERR_SUM];
   wire logic clr_rx_timeout_flag = wr_dis && lane1 && !avs_writedata_i[usr_pkg::DIS_TIMEOUT];
   wire logic clr_stat = wr_dis && lane0 && !avs_writedata_i[usr_pkg::DIS_STAT_SUM];
   wire logic clr_ovr = wr_sc && lane0 && !avs_writedata_i[usr_pkg::SC_OVERRUN];
   wire logic clr_brk = wr_sc && lane0 && !avs_writedata_i[usr_pkg::SC_BRK_DET];

   // -----------------------------------------------------------------
   // Sticky flags (set wins over clear)
   // -----------------------------------------------------------------
   logic err_sum_r;
   logic rx_timeout_flag_r;
   logic stat_sum_r;
   logic sticky_ovr_r;
   logic sticky_brk_r;
   logic [usr_pkg::SEL_W-1:0] status_interrupt_select_r;
   logic tx_space_prev_r;
   logic tx_all_prev_r;
   logic brk_prev_r;
   // Any framing, parity or overrun error, reported or caused here, sets the summary
   wire logic push_err = rx_push_stat_i.framing || rx_push_stat_i.parity || rx_push_stat_i.overrun;
   wire logic any_err = (do_push && push_err) || lost_char;
   // Selected status changes: overrun, CTS edge, break, tx space, all sent
   wire logic [usr_pkg::SEL_W-1:0] stat_events = {
      lost_char,
      cts_change,
      break_start_i,
      tx_space_i && !tx_space_prev_r,
      tx_all_empty_i && !tx_all_prev_r
   };
   wire logic stat_hit = |(stat_events & status_interrupt_select_r);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         err_sum_r <= usr_pkg::RST_ZERO;
         rx_timeout_flag_r <= usr_pkg::RST_ZERO;
         stat_sum_r <= usr_pkg::RST_ZERO;
         sticky_ovr_r <= usr_pkg::RST_ZERO;
         sticky_brk_r <= usr_pkg::RST_ZERO;
         status_interrupt_select_r <= '0;
         tx_space_prev_r <= usr_pkg::RST_ONE;
         tx_all_prev_r <= usr_pkg::RST_ONE;
         brk_prev_r <= usr_pkg::RST_ZERO;
      end else begin
         err_sum_r <= any_err | (err_sum_r & ~clr_err);
         rx_timeout_flag_r <= rx_timeout_i | (rx_timeout_flag_r & ~clr_rx_timeout_flag);
         stat_sum_r <= stat_hit | (stat_sum_r & ~clr_stat);
         sticky_ovr_r <= lost_char | (sticky_ovr_r & ~clr_ovr);
         sticky_brk_r <= break_start_i | (sticky_brk_r & ~clr_brk);
         if (wr_ic) begin
            status_interrupt_select_r <= avs_writedata_i[usr_pkg::SEL_W-1:0];
         end
         tx_space_prev_r <= tx_space_i;
         tx_all_prev_r <= tx_all_empty_i;
         brk_prev_r <= break_active_i;
      end
   end
   assign exception_interrupt_o = stat_sum_r;

   // -----------------------------------------------------------------
   // Read data assembly; reserved bits read zero
   // -----------------------------------------------------------------
   logic [31:0] dis_word;
   logic [31:0] sc_word;
   logic [31:0] rd_mux;
   always_comb begin
      dis_word = '0;
      dis_word[usr_pkg::DIS_HEAD_BREAK] = head_stat.brk;
      dis_word[usr_pkg::DIS_RX_EMPTY] = rx_empty;
      dis_word[usr_pkg::DIS_FRAMING] = head_stat.framing;
      dis_word[usr_pkg::DIS_PARITY] = head_stat.parity;
      dis_word[usr_pkg::DIS_OVERRUN] = head_stat.overrun;
      dis_word[usr_pkg::DIS_ERR_SUM] = err_sum_r;
      dis_word[usr_pkg::DIS_TIMEOUT] = rx_timeout_flag_r;
      dis_word[usr_pkg::DIS_TX_REQ] = tx_space_i;
      dis_word[usr_pkg::DIS_RX_REQ] = !rx_empty;
      dis_word[usr_pkg::DIS_STAT_SUM] = stat_sum_r;
      dis_word[usr_pkg::DIS_COUNT_LSB +: usr_pkg::COUNT_W] = count_r;
      sc_word = '0;
      sc_word[usr_pkg::SC_OVERRUN] = sticky_ovr_r;
      sc_word[usr_pkg::SC_CTS] = cts_sync_r;
      sc_word[usr_pkg::SC_BRK_PROG] = break_active_i;
      sc_word[usr_pkg::SC_TX_SPACE] = tx_space_i;
      sc_word[usr_pkg::SC_TX_ALL] = tx_all_empty_i;
      sc_word[usr_pkg::SC_BRK_DET] = sticky_brk_r;
      rd_mux = '0;
      if (sel_dis) begin
         rd_mux = dis_word;
      end else if (sel_sc) begin
         rd_mux = sc_word;
      end else if (sel_ic) begin
         rd_mux = {27'h0000000, status_interrupt_select_r};
      end
   end

   // Registered read answer; waitrequest drops one cycle after request
   logic ack_r;
   logic [31:0] rdata_r;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         rdata_r <= rd_mux;
      end
   end
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o = rdata_r;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_timeout_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rx_timeout_i |=> rx_timeout_flag_r) else $error("timeout flag not set");
   a_err_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      lost_char |=> err_sum_r && sticky_ovr_r) else $error("overrun flags not set");
   a_err_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clr_err && !any_err |=> !err_sum_r) else $error("error summary not cleared");
   a_brk_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sticky_brk_r && !clr_brk |=> sticky_brk_r) else $error("break detect lost");
   a_brk_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      break_start_i |=> sticky_brk_r) else $error("break detect not set");
   a_count_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      count_r <= usr_pkg::COUNT_MAX) else $error("count out of range");
   a_count_push: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      do_push && !do_pop |=> count_r == $past(count_r) + 5'h01) else $error("count not raised");
   a_empty_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      dis_word[usr_pkg::DIS_RX_EMPTY] != dis_word[usr_pkg::DIS_RX_REQ]) else $error("empty and valid agree");
   a_stat_raise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      stat_hit |=> exception_interrupt_o) else $error("status change missed");
   a_cts_delay: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cts_sync_r) |-> $past(cts_pin_i, 2)) else $error("cts level wrong");
   a_count_pop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      do_pop && !do_push |=> count_r == $past(count_r) - 5'h01) else $error("count not lowered");
   a_rx_timeout_flag_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clr_rx_timeout_flag && !rx_timeout_i |=> !rx_timeout_flag_r) else $error("timeout flag not cleared");
   a_ovr_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clr_ovr && !lost_char |=> !sticky_ovr_r) else $error("overrun flag not cleared");
   a_stat_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clr_stat && !stat_hit |=> !stat_sum_r) else $error("summary not cleared");
endmodule : usr_status
`default_nettype wire

// ==== tb/test_uart_status_reporting.sv ====
// Self-checking bench for the serial channel status block
`default_nettype none
module test_uart_status_reporting;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, rd_r, wr_r, pop, wreq, irq, pop_ok;
   logic [3:0] addr, be;
   logic [31:0] wd, rdata, q32;
   usr_pkg::usr_rx_stat_s pst;
   logic push, tmo, bst, bact, cts_w, txs, txa;
   int errors, compares, q[$];
   bit err, rx_timeout_flag, ovs, bkd, brk, cts, sp, all;
   usr_status u_usr_status (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd_r),
      .avs_write_i(wr_r), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .rx_push_i(push), .rx_push_stat_i(pst), .rx_pop_i(pop),
      .rx_timeout_i(tmo), .break_start_i(bst), .break_active_i(bact), .tx_space_i(txs),
      .tx_all_empty_i(txa), .cts_pin_i(cts_w), .exception_interrupt_o(irq), .rx_pop_ok_o(pop_ok));
   usr_remote_model u_usr_remote_model (.ref_clk_i(clk), .rx_push_stat_o(pst), .rx_push_o(push),
      .rx_timeout_o(tmo), .break_start_o(bst), .break_active_o(bact), .cts_pin_o(cts_w),
      .tx_space_o(txs), .tx_all_empty_o(txa));
   // ----------
   // Clock, helpers and model
   // ----------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Avalon access held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      @(posedge clk);
      rd_r <= !w;
      wr_r <= w;
      addr <= a;
      wd <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0) chk(1, 0, "no answer");
      q32 = rdata;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask : bus
   function automatic logic [31:0] dis();
      int h;
      h = q.size() ? q[0] : 0;
      return {16'h0, h[3], q.size() == 0, h[2:0], err, rx_timeout_flag, sp, q.size() != 0, 1'b0, 1'b0, 5'(q.size())};
   endfunction : dis
   task automatic regs(input string m);
      bus(0, usr_pkg::ADDR_DMA_INT_STATUS, 0, 4'hf);
      chk(q32, dis(), m);
      bus(0, usr_pkg::ADDR_STATUS_CHANGE, 0, 4'hf);
      chk(q32, {26'h0, ovs, cts, brk, sp, all, bkd}, m);
   endtask : regs
   task automatic rx(input logic [3:0] s);
      u_usr_remote_model.pulse(0, s);
      if (q.size() == 2) {ovs, err} = 2'h3;
      else begin
         q.push_back(s);
         if (s[2:0] != 3'h0) err = 1;
      end
   endtask : rx
   task automatic pop_one();
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      void'(q.pop_front());
   endtask : pop_one
   task automatic lv(input logic b, input logic c, input logic s, input logic a);
      u_usr_remote_model.level(b, c, s, a);
      {brk, cts, sp, all} = {b, c, s, a};
      repeat (4) @(posedge clk);
   endtask : lv
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // Watchdog
   initial begin
      #200us;
      errors++;
      finish_test();
   end
   // ----------
   // Tests
   // ----------
   initial begin
      {rst, rd_r, wr_r, pop, addr, be, wd} = {4'h8, 40'h0};
      {sp, all} = 2'h3;
      void'($urandom(33));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      regs("reset");
      bus(0, 4'hc, 0, 4'hf);
      chk(q32, 0, "unmapped");
      $display("test reset done");
      // Status is read before each data pop; ones leave sticky bits alone
      repeat (4) begin
         rx(4'($urandom));
         rx(4'($urandom));
         u_usr_remote_model.pulse(1, 0);
         rx_timeout_flag = 1;
         regs("two entries");
         pop_one();
         regs("one entry");
         pop_one();
         bus(1, usr_pkg::ADDR_DMA_INT_STATUS, 32'hffffffff, 4'hf);
         regs("write ones");
         bus(1, usr_pkg::ADDR_DMA_INT_STATUS, 0, 4'h2);
         {err, rx_timeout_flag} = 2'h0;
         regs("cleared");
      end
      $display("test fifo done");
      repeat (3) rx(4'h0);
      bus(0, usr_pkg::ADDR_STATUS_CHANGE, 0, 4'hf);
      chk(q32[5], 1, "overrun");
      pop_one();
      pop_one();
      regs("overrun kept");
      lv(1, 1, 0, 0);
      u_usr_remote_model.pulse(2, 0);
      bkd = 1;
      regs("break");
      lv(0, 0, 1, 1);
      regs("break over");
      bus(1, usr_pkg::ADDR_STATUS_CHANGE, 0, 4'h1);
      {ovs, bkd} = 2'h0;
      regs("sticky cleared");
      $display("test line done");
      // Each status select source raises the summary and exception output
      for (int i = 0; i < 5; i++) begin
         bus(1, usr_pkg::ADDR_INT_CONTROL, 32'(1 << i), 4'h1);
         bus(1, usr_pkg::ADDR_DMA_INT_STATUS, 0, 4'h1);
         bus(0, usr_pkg::ADDR_DMA_INT_STATUS, 0, 4'hf);
         chk({irq, q32[6]}, 0, "summary idle");
         case (i)
            0: begin lv(0, 0, 1, 0); lv(0, 0, 1, 1); end
            1: begin lv(0, 0, 0, 1); lv(0, 0, 1, 1); end
            2: u_usr_remote_model.pulse(2, 0);
            3: lv(0, 1, 1, 1);
            default: begin repeat (3) rx(4'h0); pop_one(); pop_one(); end
         endcase
         repeat (3) @(posedge clk);
         bus(0, usr_pkg::ADDR_DMA_INT_STATUS, 0, 4'hf);
         chk({irq, q32[6]}, 2'h3, "summary set");
      end
      $display("test summary done");
      finish_test();
   end
endmodule : test_uart_status_reporting
`default_nettype wire

// ==== tb/usr_remote_model.sv ====
// Behavioural remote serial device and transmitter status source
`default_nettype none
module usr_remote_model (
   // Clock
   input wire logic ref_clk_i,
   // Receiver events and line levels
   output var usr_pkg::usr_rx_stat_s rx_push_stat_o,
   output logic rx_push_o,
   output logic rx_timeout_o,
   output logic break_start_o,
   output logic break_active_o,
   output logic cts_pin_o,
   // Transmitter levels
   output logic tx_space_o,
   output logic tx_all_empty_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle line with an empty transmitter
   initial begin
      {rx_push_o, rx_timeout_o, break_start_o, break_active_o, cts_pin_o} = 5'h00;
      rx_push_stat_o = 4'h0;
      {tx_space_o, tx_all_empty_o} = 2'h3;
   end
   // One-cycle event: 0 stores a char, 1 timeout, other break start
   task automatic pulse(input int sel, input logic [3:0] st);
      @(posedge ref_clk_i);
      rx_push_stat_o <= st;
      case (sel)
         0: rx_push_o <= 1'b1;
         1: rx_timeout_o <= 1'b1;
         default: break_start_o <= 1'b1;
      endcase
      @(posedge ref_clk_i);
      {rx_push_o, rx_timeout_o, break_start_o} <= 3'h0;
      rx_push_stat_o <= ~st; // Status is not held after the pulse
   endtask : pulse
   // Line break, clear-to-send and transmitter levels
   task automatic level(input logic brk, input logic cts, input logic sp, input logic all);
      @(posedge ref_clk_i);
      break_active_o <= brk;
      cts_pin_o <= cts;
      tx_space_o <= sp;
      tx_all_empty_o <= all;
   endtask : level
endmodule : usr_remote_model
`default_nettype wire
